// ==== fcb_regs.svh ====
/*
 * constants for the flash command bus host controller: command codes,
 * identifier layout, operation limits and bus timing counts.
 * assumes a 200 MHz controller clock and an asynchronous flash part on pins.
 */
`ifndef FCB_REGS_SVH
`define FCB_REGS_SVH

// ****************************************************************
// command codes
// ****************************************************************
`define FCB_CMD_READ       8'h00
`define FCB_CMD_ID_A       8'h90
`define FCB_CMD_ID_B       8'h80
`define FCB_CMD_ERASE      8'h20
`define FCB_CMD_ERASE_VFY  8'ha0
`define FCB_CMD_PROG       8'h40
`define FCB_CMD_PROG_VFY   8'hc0
`define FCB_CMD_RESET      8'hff
`define FCB_ERASED_BYTE    8'hff
`define FCB_PRECHARGE_BYTE 8'h00

// ****************************************************************
// identifier readout
// ****************************************************************
`define FCB_ID_BYTE_SEL_BIT 0
`define FCB_ID_ENABLE_BIT   9
`define FCB_TOP_DATA_BIT    7

// ****************************************************************
// retry limits
// ****************************************************************
`define FCB_ERASE_TRIES 1000
`define FCB_PROG_TRIES  25

// ****************************************************************
// timing: figures in ns, counts derived at 5 ns per cycle
// ****************************************************************
`define FCB_CLK_NS         5
`define FCB_ERASE_PULSE_NS 10000000
`define FCB_PROG_PULSE_NS  10000
`define FCB_READ_WAIT_NS   6000
`define FCB_ERASE_PULSE_CYC ((`FCB_ERASE_PULSE_NS + `FCB_CLK_NS - 1) / `FCB_CLK_NS)
`define FCB_PROG_PULSE_CYC  ((`FCB_PROG_PULSE_NS + `FCB_CLK_NS - 1) / `FCB_CLK_NS)
`define FCB_READ_WAIT_CYC   ((`FCB_READ_WAIT_NS + `FCB_CLK_NS - 1) / `FCB_CLK_NS)
`define FCB_STROBE_CYC      4

`endif

// ==== fcb_pkg.sv ====
/*
 * types for the flash command bus host controller.
 * assumes fcb_regs.svh supplies the numeric constants.
 */
package fcb_pkg;
    typedef enum logic [2:0] {
        FCB_OP_READ = 3'h0,
        FCB_OP_ID = 3'h1,
        FCB_OP_PROGRAM = 3'h2,
        FCB_OP_ERASE = 3'h3,
        FCB_OP_RESET = 3'h4
    } fcb_op_t;
    typedef enum logic [1:0] {
        FCB_RES_OK = 2'h0,
        FCB_RES_FAIL = 2'h1,
        FCB_RES_NO_SUPPLY = 2'h2
    } fcb_res_t;
endpackage

// ==== fcb_bus_cycle.sv ====
/*
 * one asynchronous bus cycle on the flash pins: write or read.
 * assumes the caller holds addr and wdata stable while busy is high.
 */
`timescale 1ns/1ps
`include "fcb_regs.svh"
module fcb_bus_cycle #(
    parameter int ADDR_W = 17,
    parameter int STROBE_CYC = `FCB_STROBE_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic is_write,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] dq_sync,
    output logic busy,
    output logic done,
    output logic [7:0] rdata,
    output logic [ADDR_W-1:0] flash_addr,
    output logic chip_sel_n,
    output logic write_strobe_n,
    output logic out_gate_n,
    output logic [7:0] dq_out,
    output logic dq_oe
);
    import fcb_pkg::*;
    initial begin
        if (STROBE_CYC < 3 || STROBE_CYC > 255) $error("strobe length out of range");
    end
    typedef enum logic [3:0] {
        FCB_BC_IDLE = 4'b0001,
        FCB_BC_SETUP = 4'b0010,
        FCB_BC_STROBE = 4'b0100,
        FCB_BC_HOLD = 4'b1000
    } fcb_bc_t;
    fcb_bc_t st_q;
    logic wr_q;
    logic [7:0] cnt_q;
    wire cnt_end = (cnt_q == 8'h00);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= FCB_BC_IDLE;
            wr_q <= 1'b0;
            cnt_q <= 8'h00;
            busy <= 1'b0;
            done <= 1'b0;
            rdata <= 8'h00;
            flash_addr <= '0;
            chip_sel_n <= 1'b1;
            write_strobe_n <= 1'b1;
            out_gate_n <= 1'b1;
            dq_out <= 8'h00;
            dq_oe <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!cnt_end) cnt_q <= cnt_q - 8'h01;
            case (st_q)
                FCB_BC_IDLE: begin
                    if (start) begin
                        st_q <= FCB_BC_SETUP;
                        wr_q <= is_write;
                        busy <= 1'b1;
                        flash_addr <= addr;
                        dq_out <= wdata;
                        dq_oe <= is_write;
                        chip_sel_n <= 1'b0;
                    end
                end
                FCB_BC_SETUP: begin
                    // write combination: strobe and select low, gate high
                    // address captured on this later falling edge
                    st_q <= FCB_BC_STROBE;
                    cnt_q <= 8'(STROBE_CYC);
                    if (wr_q) write_strobe_n <= 1'b0;
                    else out_gate_n <= 1'b0;
                end
                FCB_BC_STROBE: begin
                    if (cnt_end) begin
                        // strobe rises first, select after, data latched
                        st_q <= FCB_BC_HOLD;
                        write_strobe_n <= 1'b1;
                        out_gate_n <= 1'b1;
                        // sampled late in the strobe: two sync stages already spent
                        if (!wr_q) rdata <= dq_sync;
                    end
                end
                default: begin
                    st_q <= FCB_BC_IDLE;
                    chip_sel_n <= 1'b1;
                    dq_oe <= 1'b0;
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            endcase
        end
    end
    wr_comb_a: assert property (@(posedge clk) disable iff (!rst_n)
        !write_strobe_n |-> (!chip_sel_n && out_gate_n && dq_oe))
        else $error("write strobe without proper select and gate");
    addr_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!write_strobe_n && $past(!write_strobe_n)) |-> $stable(flash_addr))
        else $error("address moved during write strobe");
    no_fight_a: assert property (@(posedge clk) disable iff (!rst_n)
        !out_gate_n |-> !dq_oe)
        else $error("driving data while device output enabled");
    done_time_a: assert property (@(posedge clk) disable iff (!rst_n)
        (start && !busy) |-> ##[3:300] done)
        else $error("bus cycle did not finish in time");
endmodule // fcb_bus_cycle

// ==== fcb_host.sv ====
/*
 * host controller driving a bulk-erase flash through its bus pins.
 * assumes one command at a time on cmd_valid/cmd_ready and a flash part
 * whose data pins meet dq_out/dq_oe on a shared wire built outside.
 */
// Function
// - write needs strobe, select low, gate high
// - identifier command, low bit picks byte
// - program whole array before erasing (not done here; left to the caller)
// - erase needs erase code written twice
// - wait erase pulse before erase verify
// - verify every address in sequence
// - on mismatch re-erase, limit 1000 tries
// - program set-up then program write with data
// - wait program pulse before program verify
// - on mismatch re-program, limit 25 tries
`timescale 1ns/1ps
`include "fcb_regs.svh"
module fcb_host #(
    parameter int ADDR_W = 17,
    parameter int ERASE_PULSE_CYC = `FCB_ERASE_PULSE_CYC,
    parameter int PROG_PULSE_CYC = `FCB_PROG_PULSE_CYC,
    parameter int READ_WAIT_CYC = `FCB_READ_WAIT_CYC,
    parameter int ERASE_TRIES = `FCB_ERASE_TRIES,
    parameter int PROG_TRIES = `FCB_PROG_TRIES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire fcb_pkg::fcb_op_t cmd_op,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic [7:0] cmd_data,
    input wire logic supply_ok,
    output logic cmd_ready,
    output logic rsp_valid,
    output fcb_pkg::fcb_res_t rsp_res,
    output logic [7:0] rsp_data,
    output logic [ADDR_W-1:0] rsp_addr,
    output logic program_supply_high,
    output logic [ADDR_W-1:0] flash_addr,
    output logic chip_sel_n,
    output logic write_strobe_n,
    output logic out_gate_n,
    input wire logic [7:0] dq_in,
    output logic [7:0] dq_out,
    output logic dq_oe
);
    import fcb_pkg::*;
    initial begin
        if (ADDR_W < 10 || ADDR_W > 24) $error("address width unsupported");
        // the supply wait must outlast the two synchroniser stages on supply_ok
        if (ERASE_PULSE_CYC < 1 || PROG_PULSE_CYC < 1 || READ_WAIT_CYC < 2)
            $error("pulse or wait counts too short");
        if (ERASE_TRIES < 1 || ERASE_TRIES > 65535 || PROG_TRIES < 1 || PROG_TRIES > 65535)
            $error("retry limits out of range");
    end

    // ****************************************************************
    // types and state
    // ****************************************************************
    typedef enum logic [8:0] {
        FCB_IDLE = 9'b000000001,
        FCB_SUP = 9'b000000010,
        FCB_W1 = 9'b000000100,
        FCB_W2 = 9'b000001000,
        FCB_WAIT = 9'b000010000,
        FCB_VFY = 9'b000100000,
        FCB_RD = 9'b001000000,
        FCB_CHK = 9'b010000000,
        FCB_DONE = 9'b100000000
    } fcb_st_t;
    fcb_st_t st_q;
    fcb_op_t op_q;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] end_q;
    logic [7:0] data_q;
    logic [31:0] wait_q;
    logic [15:0] tries_q;
    logic bc_start_q;
    logic bc_wr_q;
    logic [ADDR_W-1:0] bc_addr_q;
    logic [7:0] bc_data_q;
    logic [7:0] dq_s1_q;
    logic [7:0] dq_s2_q;
    logic sup_s1_q;
    logic sup_s2_q;
    logic bc_busy;
    logic bc_done;
    logic [7:0] bc_rdata;

    // ****************************************************************
    // decoding
    // ****************************************************************
    function automatic logic [7:0] fcb_first_code(input fcb_op_t op);
        case (op)
            FCB_OP_ERASE: fcb_first_code = `FCB_CMD_ERASE;
            FCB_OP_PROGRAM: fcb_first_code = `FCB_CMD_PROG;
            FCB_OP_ID: fcb_first_code = `FCB_CMD_ID_A;
            FCB_OP_RESET: fcb_first_code = `FCB_CMD_RESET;
            default: fcb_first_code = `FCB_CMD_READ;
        endcase
    endfunction
    function automatic logic fcb_odd(input logic [7:0] b);
        fcb_odd = ^b;
    endfunction
    wire is_erase = (op_q == FCB_OP_ERASE);
    wire is_prog = (op_q == FCB_OP_PROGRAM);
    wire is_id = (op_q == FCB_OP_ID);
    wire two_writes = is_erase || is_prog || (op_q == FCB_OP_RESET);
    wire has_pulse = is_erase || is_prog;
    wire [7:0] first_code = fcb_first_code(op_q);
    // erase verify and program verify codes
    wire [7:0] vfy_code = is_erase ? `FCB_CMD_ERASE_VFY : `FCB_CMD_PROG_VFY;
    // second erase code repeats; program write carries data
    wire [7:0] second_code = is_prog ? data_q : first_code;
    wire [7:0] expect_byte = is_erase ? `FCB_ERASED_BYTE : data_q;
    wire id_bad = is_id && !fcb_odd(bc_rdata);
    wire match = is_id ? !id_bad : (bc_rdata == expect_byte);
    wire last_addr = (addr_q == end_q);
    wire give_up = (tries_q == 16'h0001);
    wire wait_end = (wait_q == 32'h0);

    // ****************************************************************
    // synchronisers
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dq_s1_q <= 8'h00;
            dq_s2_q <= 8'h00;
            sup_s1_q <= 1'b0;
            sup_s2_q <= 1'b0;
        end else begin
            dq_s1_q <= dq_in;
            dq_s2_q <= dq_s1_q;
            sup_s1_q <= supply_ok;
            sup_s2_q <= sup_s1_q;
        end
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= FCB_IDLE;
            op_q <= FCB_OP_READ;
            addr_q <= '0;
            end_q <= '0;
            data_q <= 8'h00;
            wait_q <= 32'h0;
            tries_q <= 16'h0;
            bc_start_q <= 1'b0;
            bc_wr_q <= 1'b0;
            bc_addr_q <= '0;
            bc_data_q <= 8'h00;
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_res <= FCB_RES_OK;
            rsp_data <= 8'h00;
            rsp_addr <= '0;
            program_supply_high <= 1'b0;
        end else begin
            bc_start_q <= 1'b0;
            rsp_valid <= 1'b0;
            if (!wait_end) wait_q <= wait_q - 32'h1;
            case (st_q)
                FCB_IDLE: begin
                    cmd_ready <= 1'b1;
                    if (cmd_valid && cmd_ready) begin
                        cmd_ready <= 1'b0;
                        op_q <= cmd_op;
                        data_q <= cmd_data;
                        // erase walks the whole array from address zero upward
                        addr_q <= (cmd_op == FCB_OP_ERASE) ? '0 : cmd_addr;
                        end_q <= (cmd_op == FCB_OP_ERASE) ? '1 : cmd_addr;
                        tries_q <= (cmd_op == FCB_OP_ERASE) ? 16'(ERASE_TRIES)
                                                            : 16'(PROG_TRIES);
                        program_supply_high <= 1'b1;
                        // latch resets to read on supply rise; settle wait
                        wait_q <= 32'(READ_WAIT_CYC);
                        st_q <= FCB_SUP;
                    end
                end
                FCB_SUP: begin
                    if (wait_end) begin
                        // no command while supply not reported high
                        if (!sup_s2_q) begin
                            rsp_res <= FCB_RES_NO_SUPPLY;
                            st_q <= FCB_DONE;
                        end else begin
                            bc_start_q <= 1'b1;
                            bc_wr_q <= 1'b1;
                            // identifier command: low bit picks byte
                            bc_addr_q <= addr_q;
                            bc_data_q <= first_code;
                            st_q <= FCB_W1;
                        end
                    end
                end
                FCB_W1: begin
                    if (bc_done) begin
                        if (two_writes) begin
                            bc_start_q <= 1'b1;
                            bc_data_q <= second_code;
                            st_q <= FCB_W2;
                        end else begin
                            // read after latch holds read or identifier
                            wait_q <= 32'(READ_WAIT_CYC);
                            st_q <= FCB_WAIT;
                        end
                    end
                end
                FCB_W2: begin
                    if (bc_done) begin
                        // erase pulse; program pulse, timed here
                        wait_q <= is_erase ? 32'(ERASE_PULSE_CYC) : 32'(PROG_PULSE_CYC);
                        if (has_pulse) st_q <= FCB_WAIT;
                        else begin
                            rsp_res <= FCB_RES_OK;
                            st_q <= FCB_DONE;
                        end
                    end
                end
                FCB_WAIT: begin
                    if (wait_end) begin
                        bc_start_q <= 1'b1;
                        bc_addr_q <= addr_q;
                        bc_wr_q <= has_pulse;
                        // verify ends pulse, address for margin read
                        bc_data_q <= vfy_code;
                        st_q <= has_pulse ? FCB_VFY : FCB_RD;
                    end
                end
                FCB_VFY: begin
                    if (bc_done) begin
                        bc_start_q <= 1'b1;
                        bc_wr_q <= 1'b0;
                        st_q <= FCB_RD;
                    end
                end
                FCB_RD: begin
                    if (bc_done) st_q <= FCB_CHK;
                end
                FCB_CHK: begin
                    rsp_data <= bc_rdata;
                    rsp_addr <= addr_q;
                    if (!has_pulse) begin
                        rsp_res <= id_bad ? FCB_RES_FAIL : FCB_RES_OK;
                        st_q <= FCB_DONE;
                    end else if (match && !last_addr) begin
                        addr_q <= addr_q + ADDR_W'(1);
                        bc_start_q <= 1'b1;
                        bc_wr_q <= 1'b1;
                        bc_addr_q <= addr_q + ADDR_W'(1);
                        st_q <= FCB_VFY;
                    end else if (match) begin
                        rsp_res <= FCB_RES_OK;
                        st_q <= FCB_DONE;
                    end else if (give_up) begin
                        rsp_res <= FCB_RES_FAIL;
                        st_q <= FCB_DONE;
                    end else begin
                        // repeat sequence, resume at failed address
                        tries_q <= tries_q - 16'h1;
                        bc_start_q <= 1'b1;
                        bc_wr_q <= 1'b1;
                        bc_data_q <= first_code;
                        st_q <= FCB_W1;
                    end
                end
                default: begin
                    // reset code left in latch avoided: drop supply, latch read
                    program_supply_high <= 1'b0;
                    rsp_valid <= 1'b1;
                    st_q <= FCB_IDLE;
                end
            endcase
        end
    end

    fcb_bus_cycle #(.ADDR_W(ADDR_W)) u_cycle (
        .clk(clk),
        .rst_n(rst_n),
        .start(bc_start_q),
        .is_write(bc_wr_q),
        .addr(bc_addr_q),
        .wdata(bc_data_q),
        .dq_sync(dq_s2_q),
        .busy(bc_busy),
        .done(bc_done),
        .rdata(bc_rdata),
        .flash_addr(flash_addr),
        .chip_sel_n(chip_sel_n),
        .write_strobe_n(write_strobe_n),
        .out_gate_n(out_gate_n),
        .dq_out(dq_out),
        .dq_oe(dq_oe)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    // no write without supply
    wr_supply_a: assert property (@(posedge clk) disable iff (!rst_n)
        !write_strobe_n |-> program_supply_high)
        else $error("write strobe while supply low");
    erase_pair_a: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == FCB_W2 && bc_done && is_erase) |-> bc_data_q == `FCB_CMD_ERASE)
        else $error("second erase write not erase code");
    pulse_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == FCB_W2 && bc_done && has_pulse) |=> st_q == FCB_WAIT && wait_q != 32'h0)
        else $error("verify issued without pulse wait");
    vfy_code_a: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == FCB_WAIT && wait_end && has_pulse) |=> bc_data_q == vfy_code)
        else $error("wrong verify code");
    tries_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == FCB_CHK && has_pulse) |-> tries_q != 16'h0)
        else $error("retry count underflow");
    id_parity_a: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == FCB_CHK && is_id && id_bad) |=> rsp_res == FCB_RES_FAIL)
        else $error("bad identifier parity not reported");
    busy_ready_a: assert property (@(posedge clk) disable iff (!rst_n)
        bc_busy |-> !cmd_ready)
        else $error("ready while bus busy");
    prog_done_c: cover property (@(posedge clk) disable iff (!rst_n)
        rsp_valid && rsp_res == FCB_RES_OK && op_q == FCB_OP_PROGRAM);
    erase_retry_c: cover property (@(posedge clk) disable iff (!rst_n)
        st_q == FCB_CHK && is_erase && !match && !give_up);
    id_read_c: cover property (@(posedge clk) disable iff (!rst_n)
        rsp_valid && op_q == FCB_OP_ID);
endmodule // fcb_host

// ==== fcb_flash_model.sv ====
/* behavioural flash part on the host pins: command latch, array, identifier.
   assumes the bench resolves the shared data wire from both enables. */
`timescale 1ns/1ps
`include "fcb_regs.svh"
module fcb_flash_model #(
    parameter int ADDR_W = 10,
    // arbitrary identifier values, odd parity in the top bit
    parameter logic [7:0] MAKER_ID = 8'h0e,
    parameter logic [7:0] PART_ID = 8'hb3
) (
    input wire logic vpp_on,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic [7:0] din,
    input wire logic [7:0] stuck,
    output logic [7:0] dout,
    output logic dev_oe
);
    logic [7:0] mem [0:(1<<ADDR_W)-1];
    logic [7:0] cmd_q = 8'h00;
    logic [ADDR_W-1:0] a_in;
    logic [ADDR_W-1:0] a_q;
    wire wr_n = we_n | ce_n;
    wire id_m = cmd_q == `FCB_CMD_ID_A || cmd_q == `FCB_CMD_ID_B;
    wire vfy = cmd_q == `FCB_CMD_ERASE_VFY || cmd_q == `FCB_CMD_PROG_VFY;
    // drive only selected, gated, not writing
    assign dev_oe = !ce_n && !oe_n && we_n;
    // latch picks array, margin or identifier
    assign dout = stuck ^ (id_m ? (addr[0] ? PART_ID : MAKER_ID) : mem[vfy ? a_q : addr]);
    // address on the later falling edge
    always @(negedge wr_n) a_in = addr;
    // supply change returns latch to read
    always @(vpp_on) cmd_q = `FCB_CMD_READ;
    // data on earlier rise; select not needed later
    always @(posedge wr_n) if (oe_n && vpp_on) begin
        if (cmd_q == `FCB_CMD_PROG) begin
            mem[a_in] = din;
            a_q = a_in;
            cmd_q = 8'h01;
        end else begin
            // program verify reads the address latched with the program write
            if (din != `FCB_CMD_PROG_VFY) a_q = a_in;
            if (cmd_q == `FCB_CMD_ERASE && din == `FCB_CMD_ERASE) begin
                for (int i = 0; i < (1<<ADDR_W); i++) mem[i] = `FCB_ERASED_BYTE;
            end
            cmd_q = din;
        end
    end
endmodule // fcb_flash_model

// ==== test_flash_command_bus_interface.sv ====
/* self-checking bench for fcb_host against the flash model.
   assumes shortened pulse and retry counts; stuck bits force failures. */
`timescale 1ns/1ps
module test_flash_command_bus_interface;
    import fcb_pkg::*;
    localparam int AW = 10;
    logic clk = 0;
    logic rst_n = 0;
    logic cmd_valid = 0;
    logic sup_en = 0;
    fcb_op_t cmd_op = FCB_OP_READ;
    logic [AW-1:0] cmd_addr = '0;
    logic [7:0] cmd_data = 8'h00;
    logic [7:0] stuck = 8'h00;
    logic [AW-1:0] f_addr, rsp_addr;
    logic [7:0] rsp_data, dq_out, dev_dq;
    logic cmd_ready, rsp_valid, vpp, ce_n, we_n, oe_n, dq_oe, dev_oe;
    fcb_res_t rsp_res;
    int fails = 0;
    int comparisons = 0;
    // undriven wire toggles so a stale value never passes
    wire [7:0] dq = dq_oe ? dq_out : dev_oe ? dev_dq : {8{clk}} ^ 8'h5a;
    always #2.5 clk = ~clk;
    fcb_host #(.ADDR_W(AW), .ERASE_PULSE_CYC(20), .PROG_PULSE_CYC(10), .READ_WAIT_CYC(4),
        .ERASE_TRIES(3), .PROG_TRIES(3)) u_dut (.clk(clk), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .supply_ok(vpp && sup_en), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_res(rsp_res), .rsp_data(rsp_data), .rsp_addr(rsp_addr),
        .program_supply_high(vpp), .flash_addr(f_addr), .chip_sel_n(ce_n),
        .write_strobe_n(we_n), .out_gate_n(oe_n), .dq_in(dq), .dq_out(dq_out), .dq_oe(dq_oe));
    fcb_flash_model #(.ADDR_W(AW)) u_flash (.vpp_on(vpp), .addr(f_addr), .ce_n(ce_n),
        .we_n(we_n), .oe_n(oe_n), .din(dq), .stuck(stuck), .dout(dev_dq), .dev_oe(dev_oe));
    task stop_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task check(input logic [15:0] seen, input logic [15:0] want);
        comparisons++;
        if (seen !== want) begin
            fails++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    task run(input fcb_op_t op, input int a, input logic [7:0] d, input fcb_res_t res,
        input logic [7:0] rd, input bit cd);
        int n;
        @(posedge clk);
        cmd_op <= op;
        cmd_addr <= AW'(a);
        cmd_data <= d;
        cmd_valid <= 1'b1;
        do @(posedge clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        for (n = 0; n < 60000 && rsp_valid !== 1'b1; n++) @(posedge clk);
        if (n == 60000) begin
            fails++;
            stop_test();
        end
        check({14'h0, rsp_res}, {14'h0, res});
        if (cd) check({8'h00, rsp_data}, {8'h00, rd});
        if (cd) check(16'(rsp_addr), (op == FCB_OP_ERASE && res == FCB_RES_OK) ? 16'((1 << AW) - 1) : 16'(a));
    endtask
    task id_case;
        run(FCB_OP_ID, 0, 8'h00, FCB_RES_OK, 8'h0e, 1);
        run(FCB_OP_ID, 1, 8'h00, FCB_RES_OK, 8'hb3, 1);
        stuck <= 8'h01;
        run(FCB_OP_ID, 0, 8'h00, FCB_RES_FAIL, 8'h0f, 1);
        stuck <= 8'h00;
    endtask
    task program_case;
        run(FCB_OP_PROGRAM, 5, 8'ha5, FCB_RES_OK, 8'ha5, 1);
        run(FCB_OP_PROGRAM, 1023, 8'h3c, FCB_RES_OK, 8'h3c, 1);
        run(FCB_OP_READ, 5, 8'h00, FCB_RES_OK, 8'ha5, 1);
        stuck <= 8'h01;
        run(FCB_OP_PROGRAM, 7, 8'h00, FCB_RES_FAIL, 8'h01, 1);
        stuck <= 8'h00;
    endtask
    task erase_case;
        // left to the caller: only bytes 5, 7 and 1023 hold data, for run time
        run(FCB_OP_ERASE, 0, 8'h00, FCB_RES_OK, 8'hff, 1);
        run(FCB_OP_READ, 1023, 8'h00, FCB_RES_OK, 8'hff, 1);
        run(FCB_OP_RESET, 0, 8'h00, FCB_RES_OK, 8'h00, 0);
        run(FCB_OP_READ, 5, 8'h00, FCB_RES_OK, 8'hff, 1);
        stuck <= 8'h01;
        run(FCB_OP_ERASE, 0, 8'h00, FCB_RES_FAIL, 8'hfe, 1);
        stuck <= 8'h00;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        run(FCB_OP_READ, 5, 8'h00, FCB_RES_NO_SUPPLY, 8'h00, 0);
        sup_en <= 1'b1;
        id_case();
        program_case();
        erase_case();
        stop_test();
    end
    initial begin
        #(90000 * 5);
        fails++;
        stop_test();
    end
endmodule // test_flash_command_bus_interface
